// ==== rtl/imd_regs.sv ====
// indirect access, link drop cause and summary status registers on apb
`timescale 1ns/1ps
module imd_regs #(
  parameter int WIN_CYC = imd_pkg::FLD_WIN_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire imd_pkg::imd_apb_req_t apbReq,
  output imd_pkg::imd_apb_rsp_t      apbRsp,
  input  wire imd_pkg::imd_cond_t    cond,
  output logic                      linkDrop,
  output logic                      irq
);
  localparam int WW = $clog2(WIN_CYC);
  localparam logic [WW-1:0] WIN_LAST = WW'(WIN_CYC - 1);
  localparam logic [5:0]    RX_LAST  = 6'(imd_pkg::RXERR_LIMIT - 1);
  localparam logic [4:0]    CV_LAST  = 5'(imd_pkg::CODEV_LIMIT - 1);
  localparam logic [4:0]    SN_LAST  = 5'(imd_pkg::SNR_LIMIT - 1);

  typedef enum logic { ST_IDLE, ST_RESP } imd_bus_t;

  typedef struct packed {
    imd_bus_t         st;
    logic             useMem;
    logic             err;
    logic [15:0]      rd;
    logic [1:0]       cmd;
    logic [4:0]       sel;
    logic [2:0][15:0] xa;
    logic [4:0]       cause;
    logic             rxl;
    logic             pol;
    logic [15:0]      rxCnt;
    logic [4:0]       fldEn;
    logic [2:0]       irqSt;
    logic [2:0]       irqMsk;
    logic [WW-1:0]    win;
    logic [5:0]       rxc;
    logic [4:0]       cvc;
    logic [4:0]       snc;
    logic             drop;
  } imd_state_t;

  imd_state_t q_ff;
  imd_state_t nxt_q;

  function automatic logic [1:0] spaceOf(input logic [4:0] s);
    case (s)
      imd_pkg::SEL_VENDOR: spaceOf = imd_pkg::SP_VENDOR;
      imd_pkg::SEL_MMD3:   spaceOf = imd_pkg::SP_MMD3;
      imd_pkg::SEL_MMD7:   spaceOf = imd_pkg::SP_MMD7;
      default:             spaceOf = imd_pkg::SP_NONE;
    endcase
  endfunction

  function automatic logic isMapped(input logic [11:0] a);
    case (a[9:2])
      imd_pkg::IDX_XCTRL, imd_pkg::IDX_XDATA, imd_pkg::IDX_CAUSE,
      imd_pkg::IDX_PHYST, imd_pkg::IDX_RXCNT, imd_pkg::IDX_TENM,
      imd_pkg::IDX_IRQST, imd_pkg::IDX_IRQMSK,
      imd_pkg::IDX_FLDEN: isMapped = (a[11:10] == 2'h0);
      default:            isMapped = 1'b0;
    endcase
  endfunction

  logic        acc;
  logic        rdGo;
  logic        wrGo;
  logic [7:0]  idx;
  logic [1:0]  sidx;
  logic        okSpace;
  logic [15:0] curA;
  logic        inRange;
  logic        dataRd;
  logic        dataWr;
  logic        incr;
  logic        memWe;
  logic [15:0] memQ;
  logic        rxHit;
  logic        cvHit;
  logic        snHit;
  logic [4:0]  fire;

  assign acc  = apbReq.psel & apbReq.penable;
  assign rdGo = acc & ~apbReq.pwrite & (q_ff.st == ST_IDLE);
  assign wrGo = acc & apbReq.pwrite;
  assign idx  = apbReq.paddr[9:2];
  assign sidx = spaceOf(q_ff.sel);
  assign okSpace = (sidx != imd_pkg::SP_NONE);
  assign curA = okSpace ? q_ff.xa[sidx] : imd_pkg::RST_ZERO;
  // own space ends at its top address; others hold 2048 words
  assign inRange = okSpace && (curA[15:11] == 5'h00) &&
                   (sidx != imd_pkg::SP_VENDOR || curA <= imd_pkg::VENDOR_TOP);
  assign dataRd = rdGo && isMapped(apbReq.paddr) && idx == imd_pkg::IDX_XDATA &&
                  q_ff.cmd != imd_pkg::CMD_ADDR && okSpace;
  assign dataWr = wrGo && isMapped(apbReq.paddr) && idx == imd_pkg::IDX_XDATA &&
                  q_ff.cmd != imd_pkg::CMD_ADDR && okSpace;
  assign incr  = (dataRd && q_ff.cmd == imd_pkg::CMD_INCRW) || (dataWr && q_ff.cmd[1]);
  assign memWe = ce & dataWr & inRange;

  assign rxHit = cond.rxErr && q_ff.rxc == RX_LAST;
  assign cvHit = cond.codeViol && q_ff.cvc == CV_LAST;
  assign snHit = cond.snrLow && q_ff.snc == SN_LAST;
  assign fire  = q_ff.fldEn & {cond.descLoss, rxHit, cvHit, snHit, cond.sigLoss};

  imd_xmem #(
    .AW (imd_pkg::XMEM_AW),
    .DW (16)
  ) u_xmem (
    .clk   (clk),
    .ce    (ce),
    .we    (memWe),
    .addr  ({sidx, curA[10:0]}),
    .wdata (apbReq.pwdata[15:0]),
    .rdata (memQ)
  );

  always_comb begin
    logic clrCause;
    logic clrRxCnt;
    logic clrPol;
    logic [2:0] w1c;
    logic [2:0] ev;
    ev       = 3'h0;
    clrCause = 1'b0;
    clrRxCnt = 1'b0;
    clrPol   = 1'b0;
    w1c      = 3'h0;
    nxt_q    = q_ff;
    nxt_q.useMem = 1'b0;
    if (q_ff.st == ST_RESP && acc) begin
      nxt_q.st = ST_IDLE;
    end
    if (rdGo) begin
      nxt_q.st  = ST_RESP;
      nxt_q.err = ~isMapped(apbReq.paddr);
      nxt_q.rd  = imd_pkg::RST_ZERO;
      if (isMapped(apbReq.paddr)) begin
        case (idx)
          imd_pkg::IDX_XCTRL: nxt_q.rd = {q_ff.cmd, 9'h000, q_ff.sel};
          imd_pkg::IDX_XDATA: begin
            if (q_ff.cmd == imd_pkg::CMD_ADDR) begin
              nxt_q.rd = curA;
            end else begin
              nxt_q.useMem = inRange;
            end
          end
          imd_pkg::IDX_CAUSE: begin
            nxt_q.rd[imd_pkg::CAUSE_LSB +: 5] = q_ff.cause;
            clrCause = 1'b1;
          end
          imd_pkg::IDX_PHYST: begin
            nxt_q.rd[imd_pkg::SWAP_BIT] = cond.pairSwap;
            nxt_q.rd[imd_pkg::RXL_BIT]  = q_ff.rxl;
            nxt_q.rd[imd_pkg::POL_BIT]  = q_ff.pol;
          end
          imd_pkg::IDX_RXCNT: begin
            nxt_q.rd = q_ff.rxCnt;
            clrRxCnt = 1'b1;
          end
          imd_pkg::IDX_TENM: begin
            nxt_q.rd[imd_pkg::TENM_POL] = q_ff.pol;
            clrPol = 1'b1;
          end
          imd_pkg::IDX_IRQST:  nxt_q.rd[2:0] = q_ff.irqSt;
          imd_pkg::IDX_IRQMSK: nxt_q.rd[2:0] = q_ff.irqMsk;
          imd_pkg::IDX_FLDEN:  nxt_q.rd[4:0] = q_ff.fldEn;
          default:             nxt_q.rd = imd_pkg::RST_ZERO;
        endcase
      end
    end
    if (wrGo && isMapped(apbReq.paddr)) begin
      case (idx)
        imd_pkg::IDX_XCTRL: begin
          nxt_q.cmd = apbReq.pwdata[imd_pkg::CMD_LSB +: 2];
          nxt_q.sel = apbReq.pwdata[4:0];
        end
        imd_pkg::IDX_XDATA: begin
          if (q_ff.cmd == imd_pkg::CMD_ADDR && okSpace) begin
            nxt_q.xa[sidx] = apbReq.pwdata[15:0];
          end
        end
        imd_pkg::IDX_IRQST:  w1c = apbReq.pwdata[2:0];
        imd_pkg::IDX_IRQMSK: nxt_q.irqMsk = apbReq.pwdata[2:0];
        imd_pkg::IDX_FLDEN:  nxt_q.fldEn = apbReq.pwdata[4:0];
        default:             nxt_q.fldEn = q_ff.fldEn;
      endcase
    end
    if (incr) begin
      nxt_q.xa[sidx] = curA + 16'h0001;
    end
    // fixed windows of WIN_CYC cycles (10 us with the default) for the counted conditions
    if (q_ff.win == WIN_LAST) begin
      nxt_q.win = '0;
      nxt_q.rxc = 6'h00;
      nxt_q.cvc = 5'h00;
      nxt_q.snc = 5'h00;
    end else begin
      nxt_q.win = q_ff.win + WW'(1);
      if (cond.rxErr) begin
        nxt_q.rxc = rxHit ? 6'h00 : q_ff.rxc + 6'h01;
      end
      if (cond.codeViol) begin
        nxt_q.cvc = cvHit ? 5'h00 : q_ff.cvc + 5'h01;
      end
      if (cond.snrLow) begin
        nxt_q.snc = snHit ? 5'h00 : q_ff.snc + 5'h01;
      end
    end
    nxt_q.drop  = |fire;
    nxt_q.cause = (clrCause ? 5'h00 : q_ff.cause) | fire;
    nxt_q.rxl   = (clrRxCnt ? 1'b0 : q_ff.rxl) | cond.rxErr;
    nxt_q.pol   = (clrPol ? 1'b0 : q_ff.pol) | cond.polInv;
    if (clrRxCnt) begin
      nxt_q.rxCnt = {15'h0000, cond.rxErr};
    end else if (cond.rxErr && q_ff.rxCnt != 16'hffff) begin
      nxt_q.rxCnt = q_ff.rxCnt + 16'h0001;
    end
    ev[imd_pkg::IRQ_DROP]  = |fire;
    ev[imd_pkg::IRQ_RXERR] = cond.rxErr;
    ev[imd_pkg::IRQ_POL]   = cond.polInv & ~q_ff.pol;
    nxt_q.irqSt = (q_ff.irqSt & ~w1c) | ev;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end

  assign apbRsp.pready  = acc & (apbReq.pwrite | q_ff.st == ST_RESP);
  assign apbRsp.pslverr = apbRsp.pready &
                          (apbReq.pwrite ? ~isMapped(apbReq.paddr) : q_ff.err);
  assign apbRsp.prdata  = {16'h0000, q_ff.useMem ? memQ : q_ff.rd};
  assign linkDrop       = q_ff.drop;
  assign irq            = |(q_ff.irqSt & q_ff.irqMsk);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence physRead;
    ce && rdGo && idx == imd_pkg::IDX_PHYST && isMapped(apbReq.paddr);
  endsequence
  sequence causeRead;
    ce && rdGo && idx == imd_pkg::IDX_CAUSE && isMapped(apbReq.paddr);
  endsequence
  sequence tenmRead;
    ce && rdGo && idx == imd_pkg::IDX_TENM && isMapped(apbReq.paddr);
  endsequence
  sequence cntRead;
    ce && rdGo && idx == imd_pkg::IDX_RXCNT && isMapped(apbReq.paddr);
  endsequence
  sequence readAccess;
    ce && rdGo;
  endsequence
  sequence ctrlWrite;
    ce && wrGo && isMapped(apbReq.paddr) && idx == imd_pkg::IDX_XCTRL;
  endsequence

  // bus timing: reads wait one cycle, writes none
  rd_wait_a: assert property (readAccess |-> !apbRsp.pready)
    else $error("read answered without wait state");
  rd_ready_a: assert property (readAccess ##1 acc |-> apbRsp.pready)
    else $error("read answer missing after wait state");
  wr_ready_a: assert property (acc && apbReq.pwrite |-> apbRsp.pready)
    else $error("write not answered at once");
  idle_ready_a: assert property (!acc |-> !apbRsp.pready)
    else $error("ready outside access phase");
  wr_slverr_a: assert property (acc && apbReq.pwrite && !isMapped(apbReq.paddr) |-> apbRsp.pslverr)
    else $error("unmapped write without error");
  // clock enable low must hold every bit of state
  ce_freeze_a: assert property (!ce |=> q_ff == $past(q_ff))
    else $error("state moved while frozen");

  ctrl_write_a: assert property (ctrlWrite |=> q_ff.cmd == $past(apbReq.pwdata[15:14]) &&
    q_ff.sel == $past(apbReq.pwdata[4:0]))
    else $error("control write not stored");
  no_incr_a: assert property (ce && dataRd && q_ff.cmd == imd_pkg::CMD_DATA |=> $stable(q_ff.xa))
    else $error("address moved without increment command");
  cause_resv_a: assert property (causeRead |=> apbRsp.prdata[15:9] == 7'h00 &&
    apbRsp.prdata[3:0] == 4'h0)
    else $error("reserved cause bits not zero");
  drop_quiet_a: assert property (ce && fire == 5'h00 |=> !linkDrop)
    else $error("link drop without enabled condition");
  rxl_set_a: assert property (ce && cond.rxErr |=> q_ff.rxl)
    else $error("receive error not latched");
  rxl_clear_a: assert property (cntRead and !cond.rxErr |=> !q_ff.rxl)
    else $error("counter read did not clear latch");
  pol_set_a: assert property (ce && cond.polInv |=> q_ff.pol)
    else $error("polarity not latched");
  pol_clear_a: assert property (tenmRead and !cond.polInv |=> !q_ff.pol)
    else $error("polarity register read did not clear latch");
  irq_drop_a: assert property (ce && fire != 5'h00 && q_ff.irqMsk[imd_pkg::IRQ_DROP] |=> irq)
    else $error("link drop interrupt missing");

  addr_load_a: assert property (ce && wrGo && isMapped(apbReq.paddr) && idx == imd_pkg::IDX_XDATA &&
    q_ff.cmd == imd_pkg::CMD_ADDR && okSpace |=> q_ff.xa[$past(sidx)] == $past(apbReq.pwdata[15:0]))
    else $error("address mode write not stored");
  post_incr_a: assert property (ce && incr |=> q_ff.xa[$past(sidx)] == $past(curA) + 16'h0001)
    else $error("post increment missing");
  wr_only_inc_a: assert property (ce && dataRd && q_ff.cmd == imd_pkg::CMD_INCW |=> $stable(q_ff.xa))
    else $error("read advanced address in write-only mode");
  bad_space_a: assert property (memWe |-> okSpace && inRange)
    else $error("write into ignored space");
  vendor_top_a: assert property (memWe && sidx == imd_pkg::SP_VENDOR |-> curA <= imd_pkg::VENDOR_TOP)
    else $error("own space write above top");
  cause_enable_a: assert property (ce && fire == 5'h00 |=> (q_ff.cause & ~$past(q_ff.cause)) == 5'h00)
    else $error("cause set without enabled condition");
  energy_cause_a: assert property (ce && q_ff.fldEn[0] && cond.sigLoss |=> q_ff.cause[0] && linkDrop)
    else $error("energy loss cause not latched");
  fld_clear_a: assert property (causeRead and (fire == 5'h00) |=> q_ff.cause == 5'h00)
    else $error("cause not cleared by read");
  rx_window_a: assert property (ce && q_ff.fldEn[3] && rxHit |=> linkDrop && q_ff.cause[3] && q_ff.rxc == 6'h00)
    else $error("receive error drop missed");
  cv_window_a: assert property (ce && q_ff.fldEn[2] && cvHit |=> linkDrop && q_ff.cause[2])
    else $error("coding violation drop missed");
  swap_bit_a: assert property (physRead |=> apbRsp.prdata[imd_pkg::SWAP_BIT] == $past(cond.pairSwap))
    else $error("pair swap bit wrong");
  rxl_hold_a: assert property (ce && q_ff.rxl && !(rdGo && idx == imd_pkg::IDX_RXCNT) |=> q_ff.rxl)
    else $error("receive error latch lost");
  pol_keep_a: assert property (physRead and q_ff.pol |=> q_ff.pol)
    else $error("summary read cleared polarity");
endmodule

// ==== rtl/imd_pkg.sv ====
// constants and carrier types for the indirect access and status bank
package imd_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FLD_WINDOW_NS = 10000;
  localparam int FLD_WIN_CYC   = FLD_WINDOW_NS / CLK_PERIOD_NS;
  localparam int RXERR_LIMIT   = 32;
  localparam int CODEV_LIMIT   = 20;
  localparam int SNR_LIMIT     = 20;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_XCTRL  = 8'h0d;
  localparam logic [7:0] IDX_XDATA  = 8'h0e;
  localparam logic [7:0] IDX_CAUSE  = 8'h0f;
  localparam logic [7:0] IDX_PHYST  = 8'h10;
  localparam logic [7:0] IDX_RXCNT  = 8'h15;
  localparam logic [7:0] IDX_TENM   = 8'h1a;
  localparam logic [7:0] IDX_IRQST  = 8'h30;
  localparam logic [7:0] IDX_IRQMSK = 8'h31;
  localparam logic [7:0] IDX_FLDEN  = 8'h32;

  localparam logic [1:0] CMD_ADDR  = 2'h0;
  localparam logic [1:0] CMD_DATA  = 2'h1;
  localparam logic [1:0] CMD_INCRW = 2'h2;
  localparam logic [1:0] CMD_INCW  = 2'h3;
  localparam int CMD_LSB = 14;

  localparam logic [4:0] SEL_VENDOR = 5'h1f;
  localparam logic [4:0] SEL_MMD3   = 5'h03;
  localparam logic [4:0] SEL_MMD7   = 5'h07;
  localparam logic [1:0] SP_VENDOR  = 2'h0;
  localparam logic [1:0] SP_MMD3    = 2'h1;
  localparam logic [1:0] SP_MMD7    = 2'h2;
  localparam logic [1:0] SP_NONE    = 2'h3;
  localparam logic [15:0] VENDOR_TOP = 16'h04d1;
  localparam int XMEM_AW = 13;

  localparam int CAUSE_LSB   = 4;
  localparam int SWAP_BIT    = 14;
  localparam int RXL_BIT     = 13;
  localparam int POL_BIT     = 12;
  localparam int TENM_POL    = 4;
  localparam int IRQ_DROP    = 0;
  localparam int IRQ_RXERR   = 1;
  localparam int IRQ_POL     = 2;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } imd_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } imd_apb_rsp_t;

  // conditions from the receive datapath, same clock
  typedef struct packed {
    logic descLoss;
    logic rxErr;
    logic codeViol;
    logic snrLow;
    logic sigLoss;
    logic pairSwap;
    logic polInv;
  } imd_cond_t;
endpackage

// ==== rtl/imd_xmem.sv ====
// extended register storage, registered read data
`timescale 1ns/1ps
module imd_xmem #(
  parameter int AW = 13,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// ==== verif/imd_regs_test.sv ====
// self-checking bench for the indirect access and status bank
`timescale 1ns/1ps
module imd_regs_test;
  localparam int WIN = 40;
  logic                  clk;
  logic                  rstn;
  logic                  ce;
  imd_pkg::imd_apb_req_t req;
  imd_pkg::imd_apb_rsp_t rsp;
  imd_pkg::imd_cond_t    cond;
  logic                  linkDrop;
  logic                  irq;
  int                    err_total;
  int                    cmp_count;
  int                    ldCount;
  int                    cyc;
  int                    n0;
  logic [32:0]           expQ[$];
  logic [32:0]           ent;
  logic [15:0]           d[3];
  logic [15:0]           base;
  logic [4:0]            sel[3] = '{5'h1f, 5'h03, 5'h07};

  imd_regs #(.WIN_CYC(WIN)) dut_u (.clk(clk), .rstn(rstn), .ce(ce), .apbReq(req), .apbRsp(rsp),
                                   .cond(cond), .linkDrop(linkDrop), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // request held until the edge at which pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0}, pwdata: {16'h0, wd}};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    chk("pready", 33'h1, {32'h0, rsp.pready});
    @(posedge clk);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] e, input logic [15:0] m = 16'hffff,
                    input logic er = 1'b0);
    expQ.push_back({er, m, e});
    apb(1'b0, idx, 16'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    apb(1'b1, idx, v);
  endtask

  // holds the chosen conditions for two whole windows
  task automatic drive(input logic [4:0] v);
    @(posedge clk);
    cond <= imd_pkg::imd_cond_t'({v, 2'b00});
    repeat (2 * WIN) @(posedge clk);
    cond <= '0;
  endtask

  // monitor: each completed read against the oldest note
  always @(negedge clk) begin
    if (linkDrop === 1'b1) ldCount++;
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      if (expQ.size() == 0) begin
        ent = 33'h0;
        chk("unexpected read", 33'h0, 33'h1);
      end else begin
        ent = expQ.pop_front();
        chk("read", {ent[32], 16'h0, ent[15:0] & ent[31:16]}, {rsp.pslverr, rsp.prdata & {16'hffff, ent[31:16]}});
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    rstn      = 1'b0;
    ce        = 1'b1;
    req       = '0;
    cond      = '0;
    err_total = 0;
    cmp_count = 0;
    ldCount   = 0;
    cyc       = 0;
    void'($urandom(2));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(imd_pkg::IDX_XCTRL, 16'h0);
    rd(imd_pkg::IDX_XDATA, 16'h0);
    rd(imd_pkg::IDX_CAUSE, 16'h0);
    rd(imd_pkg::IDX_PHYST, 16'h0, 16'h7000);
    rd(8'h20, 16'h0, 16'hffff, 1'b1);
    wr(imd_pkg::IDX_CAUSE, 16'hffff);
    rd(imd_pkg::IDX_CAUSE, 16'h0);
    wr(imd_pkg::IDX_XCTRL, 16'hffff);
    rd(imd_pkg::IDX_XCTRL, 16'hc01f);
    foreach (sel[s]) begin
      base = (s == 0) ? 16'h04cf : 16'h0100;
      wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_ADDR, 9'h0, sel[s]});
      wr(imd_pkg::IDX_XDATA, base);
      wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_INCRW, 9'h0, sel[s]});
      for (int k = 0; k < 3; k++) begin
        d[k] = 16'($urandom());
        wr(imd_pkg::IDX_XDATA, d[k]);
      end
      wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_ADDR, 9'h0, sel[s]});
      rd(imd_pkg::IDX_XDATA, base + 16'h3);
      wr(imd_pkg::IDX_XDATA, base);
      wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_INCRW, 9'h0, sel[s]});
      rd(imd_pkg::IDX_XDATA, d[0]);
      rd(imd_pkg::IDX_XDATA, d[1]);
      wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_INCW, 9'h0, sel[s]});
      rd(imd_pkg::IDX_XDATA, d[2]);
      rd(imd_pkg::IDX_XDATA, d[2]);
      wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_DATA, 9'h0, sel[s]});
      rd(imd_pkg::IDX_XDATA, d[2]);
      wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_ADDR, 9'h0, sel[s]});
      rd(imd_pkg::IDX_XDATA, base + 16'h2);
    end
    wr(imd_pkg::IDX_XCTRL, {imd_pkg::CMD_DATA, 9'h0, 5'h05});
    wr(imd_pkg::IDX_XDATA, 16'hbeef);
    rd(imd_pkg::IDX_XDATA, 16'h0);
    // link drop causes, first with every condition disabled
    wr(imd_pkg::IDX_IRQMSK, 16'h0001);
    drive(5'h1f);
    rd(imd_pkg::IDX_CAUSE, 16'h0);
    for (int i = 0; i < 5; i++) begin
      wr(imd_pkg::IDX_FLDEN, 16'(1 << i));
      n0 = ldCount;
      drive(5'(1 << i));
      rd(imd_pkg::IDX_CAUSE, 16'(1 << (i + 4)));
      rd(imd_pkg::IDX_CAUSE, 16'h0);
      chk("linkDrop", 33'h1, 33'(ldCount > n0));
    end
    chk("irq set", 33'h1, {32'h0, irq});
    wr(imd_pkg::IDX_IRQMSK, 16'h0000);
    rd(imd_pkg::IDX_IRQST, 16'h0001, 16'h0001);
    chk("irq masked", 33'h0, {32'h0, irq});
    wr(imd_pkg::IDX_IRQST, 16'h0007);
    wr(imd_pkg::IDX_IRQMSK, 16'h0001);
    rd(imd_pkg::IDX_IRQST, 16'h0);
    chk("irq clear", 33'h0, {32'h0, irq});
    // receive error latch against its counter register
    rd(imd_pkg::IDX_RXCNT, 16'h0, 16'h0);
    @(posedge clk);
    cond <= imd_pkg::imd_cond_t'(7'h20);
    @(posedge clk);
    cond <= '0;
    rd(imd_pkg::IDX_PHYST, 16'h2000, 16'h2000);
    rd(imd_pkg::IDX_RXCNT, 16'h0001);
    rd(imd_pkg::IDX_PHYST, 16'h0, 16'h2000);
    // pair swap live, polarity latch cleared only by its own register
    @(posedge clk);
    cond <= imd_pkg::imd_cond_t'(7'h03);
    @(posedge clk);
    cond.polInv <= 1'b0;
    rd(imd_pkg::IDX_PHYST, 16'h5000, 16'h5000);
    rd(imd_pkg::IDX_PHYST, 16'h1000, 16'h1000);
    rd(imd_pkg::IDX_TENM, 16'h0010, 16'h0010);
    rd(imd_pkg::IDX_PHYST, 16'h4000, 16'h5000);
    rd(imd_pkg::IDX_IRQST, 16'h0006);
    // errors while frozen must not count
    @(posedge clk);
    ce   <= 1'b0;
    cond <= imd_pkg::imd_cond_t'(7'h20);
    repeat (3) @(posedge clk);
    cond <= '0;
    ce   <= 1'b1;
    rd(imd_pkg::IDX_RXCNT, 16'h0);
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule
